// file: bench/dmls_chk_sva.sv
// Assertion checker for the DAC and mailbox link router ports.
`timescale 1ns/1ps
`include "dmls_defs.svh"

module dmls_chk #(
	parameter int N_CHAN = 3,
	parameter int WORD_W = 16
) (
	input wire logic                               i_core_clk,
	input wire logic                               i_reset_n,
	input wire logic                               i_reg_wr,
	input wire logic [9:0]                         i_reg_addr,
	input wire logic [15:0]                        i_reg_wdata,
	input wire logic                               i_cfg_lock,
	input wire logic [15:0]                        o_reg_rdata,
	input wire logic                               o_reg_rvalid,
	input wire logic [2*N_CHAN-1:0]                i_select_special_pair_instr,
	input wire logic [2*N_CHAN-1:0]                i_link_instr_set,
	input wire logic [2*N_CHAN-1:0][2:0]           i_link_instr_val,
	input wire dmls_pkg::dmls_dac_t [2*N_CHAN-1:0] o_dac_own_same,
	input wire dmls_pkg::dmls_dac_t [2*N_CHAN-1:0] o_dac_own_opp,
	input wire dmls_pkg::dmls_dac_t [2*N_CHAN-1:0] o_dac_other_same,
	input wire dmls_pkg::dmls_dac_t [2*N_CHAN-1:0] o_dac_other_opp,
	input wire dmls_pkg::dmls_dac_t [2*N_CHAN-1:0] o_special_dac_pair,
	input wire logic [2*N_CHAN-1:0]                o_shared_control_split,
	input wire dmls_pkg::dmls_core_t [2*N_CHAN-1:0] o_link_target,
	input wire logic [2*N_CHAN-1:0]                o_link_is_sum,
	input wire logic [N_CHAN-1:0]                  o_stop_chan
);
	import dmls_pkg::*;

	// ****************
	// Clocking and write decodes.
	// ****************
	// All checks sample on the core clock and pause during reset.
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_reset_n);
	wire cfg1_wr = i_reg_wr && i_reg_addr == `DMLS_CFG_CH1_OFF;
	wire cfg3_wr = i_reg_wr && i_reg_addr == `DMLS_CFG_CH3_OFF;

	// ****************
	// Properties.
	// ****************
	stop_pulse_a: assert property (
		i_reg_wr && i_reg_addr == `DMLS_STOP_CH2_OFF &&
		i_reg_wdata == `DMLS_STOP_CODE |=> o_stop_chan == 3'h2)
		else $error("stop pulse missing");
	stop_quiet_a: assert property (
		!(i_reg_wr && i_reg_wdata == `DMLS_STOP_CODE) |=> o_stop_chan == 3'h0)
		else $error("stray stop pulse");
	rsvd_zero_a: assert property (
		o_reg_rvalid |-> (o_reg_rdata & ~`DMLS_CFG_MASK) == 16'h0000)
		else $error("reserved bits read nonzero");
	own_pair_a: assert property ($past(i_reset_n) |->
		o_dac_own_same[0] == 3'h1 && o_dac_own_opp[0] == 3'h2 &&
		o_dac_own_same[5] == 3'h6 && o_dac_own_opp[5] == 3'h5)
		else $error("own pair wrong");
	other_pair_a: assert property ($past(i_reset_n) |->
		o_dac_other_opp[0] == o_dac_other_same[0] + 3'h1 &&
		o_dac_other_opp[1] == o_dac_other_same[1] - 3'h1)
		else $error("other pair order wrong");
	special_sel_a: assert property (
		cfg1_wr && i_reg_wdata[4] && !i_select_special_pair_instr[0] |->
		##2 o_special_dac_pair[0] == `DMLS_SPECIAL_DAC_B)
		else $error("special pair not six");
	split_lock_a: assert property (cfg1_wr && i_cfg_lock |-> ##2
		o_shared_control_split[1:0] == $past(o_shared_control_split[1:0]))
		else $error("shared bits changed under lock");
	sum_mode_a: assert property (cfg1_wr && !i_link_instr_set[0] |-> ##2
		o_link_is_sum[0] == ($past(i_reg_wdata[10], 2) &&
		!$past(i_reg_wdata[9], 2)))
		else $error("sum flag wrong");
	link_wrap_a: assert property (
		cfg3_wr && i_reg_wdata[10:8] == 3'h3 && !i_link_instr_set[4] |->
		##2 o_link_target[4] == 3'h1)
		else $error("link wrap wrong");
	link_instr_a: assert property (
		i_link_instr_set[1] && i_link_instr_val[1] == 3'h1 |->
		##2 o_link_target[1] == 3'h0)
		else $error("instruction link wrong");
	cover property (o_stop_chan != 3'h0);
	cover property (o_link_is_sum != 6'h00);
	cover property (cfg1_wr && i_cfg_lock);
endmodule : dmls_chk

bind dmls_top dmls_chk #(.N_CHAN(N_CHAN), .WORD_W(WORD_W)) u_chk (.*);

// file: bench/dmls_host_bfm.sv
// Host model that drives the register port of the router.
`timescale 1ns/1ps

module dmls_host_bfm (
	input  wire logic        i_core_clk,
	input  wire logic        i_reg_rvalid,
	input  wire logic [15:0] i_reg_rdata,
	output logic             o_reg_wr,
	output logic             o_reg_rd,
	output logic [9:0]       o_reg_addr,
	output logic [15:0]      o_reg_wdata
);
	// Idle bus at time zero.
	initial begin
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_addr = 10'h000;
		o_reg_wdata = 16'h0000;
	end

	// One write, called just after an edge; released lines show the inverse.
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		o_reg_addr = a;
		o_reg_wdata = d;
		o_reg_wr = 1'b1;
		@(posedge i_core_clk);
		#1;
		o_reg_wr = 1'b0;
		o_reg_addr = ~a;
		o_reg_wdata = ~d;
		// Let one edge pass so a following call never re-drives this step.
		@(posedge i_core_clk);
		#1;
	endtask : wr

	// One read with a bounded wait for the answer; addresses with low five bits 13 hex, such as the stop ports, return unread.
	task automatic rd(input logic [9:0] a, output logic [15:0] d,
		output bit ok);
		d = 16'h0000;
		ok = 1'b0;
		if (a[4:0] == 5'h13) return;
		o_reg_addr = a;
		o_reg_rd = 1'b1;
		@(posedge i_core_clk);
		#1;
		o_reg_rd = 1'b0;
		o_reg_addr = ~a;
		for (int n = 0; n < 4 && !ok; n++) begin
			if (i_reg_rvalid === 1'b1) begin
				d = i_reg_rdata;
				ok = 1'b1;
			end else begin
				@(posedge i_core_clk);
				#1;
			end
		end
		// Let one edge pass so a following call never re-drives this step.
		@(posedge i_core_clk);
		#1;
	endtask : rd
endmodule : dmls_host_bfm

// file: bench/tb_dac_and_mailbox_link_select.sv
// Self-checking bench for the DAC and mailbox link router.
`timescale 1ns/1ps

module tb_dac_and_mailbox_link_select;
	import dmls_pkg::*;
	typedef struct packed {
		logic [1:0]  ch;
		logic [15:0] cfg;
		dmls_dac_t   oth0;
		dmls_dac_t   oth1;
		dmls_core_t  tgt0;
		dmls_core_t  tgt1;
	} dmls_row_t;
	// Channel, config, other-pair DAC and link target of each core.
	localparam dmls_row_t ROWS [6] = '{
		'{2'h0, 16'h0000, 3'h3, 3'h4, 3'h0, 3'h1},
		'{2'h0, 16'h1A3F, 3'h5, 3'h6, 3'h2, 3'h2},
		'{2'h1, 16'h0004, 3'h1, 3'h6, 3'h2, 3'h3},
		'{2'h1, 16'h3E0A, 3'h5, 3'h2, 3'h0, 3'h0},
		'{2'h2, 16'h0B08, 3'h1, 3'h4, 3'h1, 3'h4},
		'{2'h2, 16'h3614, 3'h3, 3'h2, 3'h2, 3'h3}
	};
	logic             i_core_clk = 1'b0;
	logic             i_reset_n, i_reg_wr, i_reg_rd, i_cfg_lock, o_reg_rvalid;
	logic [9:0]       i_reg_addr;
	logic [15:0]      i_reg_wdata, o_reg_rdata;
	logic [5:0]       i_dir_instr_set, i_dir_instr_val, i_special_instr_val;
	logic [5:0]       i_select_special_pair_instr, i_link_instr_set;
	logic [5:0][2:0]  i_link_instr_val;
	logic [5:0][15:0] i_comm_word, o_link_rdata;
	dmls_dac_t [5:0]  o_dac_own_same, o_dac_own_opp, o_dac_other_same;
	dmls_dac_t [5:0]  o_dac_other_opp, o_special_dac_pair;
	dmls_core_t [5:0] o_link_target;
	logic [5:0]       o_shared_control_split, o_link_is_sum;
	logic [2:0]       o_stop_chan;
	int               err_count = 0;
	int               checked = 0;

	// Clock, design and host model.
	always #5 i_core_clk = ~i_core_clk;
	dmls_top dut (.*);
	dmls_host_bfm host (
		.i_core_clk  (i_core_clk),
		.i_reg_rvalid(o_reg_rvalid),
		.i_reg_rdata (o_reg_rdata),
		.o_reg_wr    (i_reg_wr),
		.o_reg_rd    (i_reg_rd),
		.o_reg_addr  (i_reg_addr),
		.o_reg_wdata (i_reg_wdata)
	);

	// ****************
	// Helpers.
	// ****************
	function automatic logic [9:0] cfg_at(input int c);
		return 10'h112 + 10'(c) * 10'h020;
	endfunction : cfg_at
	task automatic step(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask : step
	task automatic chk(input string nm, input logic [15:0] s, e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	task automatic rdc(input logic [9:0] a, input logic [15:0] e);
		logic [15:0] d;
		bit          ok;
		host.rd(a, d, ok);
		if (!ok) begin
			err_count++;
			$display("MISMATCH read answer expected 1 seen 0");
			end_sim();
		end else begin
			chk("read data", d, e);
		end
	endtask : rdc

	// ****************
	// Main sequence.
	// ****************
	initial begin
		dmls_row_t r;
		int        k;
		dmls_dac_t e;
		dmls_core_t t;
		i_reset_n = 1'b0;
		i_cfg_lock = 1'b0;
		i_dir_instr_set = 6'h00;
		i_dir_instr_val = 6'h00;
		i_special_instr_val = 6'h00;
		i_select_special_pair_instr = 6'h00;
		i_link_instr_set = 6'h00;
		i_link_instr_val = '0;
		foreach (i_comm_word[n]) i_comm_word[n] = {4'(n + 8), 4'(n + 1), 8'(n)};
		step(4);
		i_reset_n = 1'b1;
		for (int c = 0; c < 3; c++) rdc(cfg_at(c), 16'h0000);
		chk("stop idle", o_stop_chan, 16'h0000);
		rdc(10'h114, 16'h0000);
		host.wr(cfg_at(0), 16'hFFFF);
		rdc(cfg_at(0), 16'h3F3F);
		i_cfg_lock = 1'b1;
		host.wr(cfg_at(0), 16'h0100);
		i_cfg_lock = 1'b0;
		rdc(cfg_at(0), 16'h0103);
		$display("Test done: reset, reserved bits and lock");
		foreach (ROWS[n]) begin
			r = ROWS[n];
			host.wr(cfg_at(r.ch), r.cfg);
			step(1);
			rdc(cfg_at(r.ch), r.cfg & 16'h3F3F);
			for (int j = 0; j < 2; j++) begin
				k = 2 * r.ch + j;
				e = j ? r.oth1 : r.oth0;
				t = j ? r.tgt1 : r.tgt0;
				chk("own same", o_dac_own_same[k], 2 * r.ch + 1 + j);
				chk("own opp", o_dac_own_opp[k], 2 * r.ch + 2 - j);
				chk("other same", o_dac_other_same[k], e);
				chk("other opp", o_dac_other_opp[k], j ? e - 1 : e + 1);
				chk("special", o_special_dac_pair[k], r.cfg[4 + j] ? 6 : 5);
				chk("split", o_shared_control_split[k], r.cfg[j]);
				chk("target", o_link_target[k], t);
				chk("window", o_link_rdata[k], i_comm_word[t]);
				chk("sum flag", o_link_is_sum[k], 16'h0000);
			end
		end
		$display("Test done: routing table");
		fork
			host.wr(cfg_at(2), 16'h2D00);
			begin
				i_link_instr_set = 6'h22;
				i_link_instr_val[5] = 3'h4;
				i_link_instr_val[1] = 3'h1;
				i_dir_instr_set = 6'h01;
				i_select_special_pair_instr = 6'h01;
				step(1);
				i_link_instr_set = 6'h00;
				i_dir_instr_set = 6'h00;
				i_select_special_pair_instr = 6'h00;
			end
		join
		step(1);
		chk("sum high", o_link_rdata[5], 16'h003F);
		chk("sum low", o_link_rdata[4], 16'h0015);
		chk("sum flag", o_link_is_sum[5], 16'h0001);
		chk("instr target", o_link_target[1], 16'h0000);
		chk("instr dir", o_dac_other_same[0], 16'h0003);
		chk("instr pair", o_special_dac_pair[0], 16'h0005);
		rdc(cfg_at(2), 16'h2500);
		rdc(cfg_at(0), 16'h0A2B);
		host.wr(cfg_at(0), 16'h2C00);
		chk("sum high core 0", o_link_rdata[0], 16'h003F);
		chk("sum low core 1", o_link_rdata[1], 16'h0015);
		chk("sum flag core 0", o_link_is_sum[0], 16'h0001);
		$display("Test done: instructions and sums");
		i_reset_n = 1'b0;
		step(2);
		chk("reset sum flags", o_link_is_sum, 16'h0000);
		chk("reset own pair", o_dac_own_same[0], 16'h0000);
		i_reset_n = 1'b1;
		rdc(cfg_at(0), 16'h0000);
		chk("routing after reset", o_dac_own_same[0], 16'h0001);
		$display("Test done: reset in mid-run");
		for (int c = 0; c < 3; c++) begin
			fork
				host.wr(cfg_at(c) + 10'h001, 16'hBEEF);
				begin
					step(1);
					chk("stop pulse", o_stop_chan, 16'h0001 << c);
				end
			join
			chk("stop end", o_stop_chan, 16'h0000);
		end
		fork
			host.wr(10'h133, 16'hBEEE);
			begin
				step(1);
				chk("stop bad code", o_stop_chan, 16'h0000);
			end
		join
		$display("Test done: stop port");
		end_sim();
	end
endmodule : tb_dac_and_mailbox_link_select

// file: rtl/dmls_defs.svh
// Register offsets, field positions, reset values and codes of the router.
`ifndef DMLS_DEFS_SVH
`define DMLS_DEFS_SVH

// ****************************************************************
// Register offsets, one pair per actuation channel.
// ****************************************************************
`define DMLS_CFG_CH1_OFF   10'h112
`define DMLS_STOP_CH1_OFF  10'h113
`define DMLS_CFG_CH2_OFF   10'h132
`define DMLS_STOP_CH2_OFF  10'h133
`define DMLS_CFG_CH3_OFF   10'h152
`define DMLS_STOP_CH3_OFF  10'h153

// ****************************************************************
// Field positions of the routing configuration register.
// ****************************************************************
`define DMLS_SHARED_LSB    0
`define DMLS_DIR_LSB       2
`define DMLS_SPECIAL_LSB   4
`define DMLS_LINK0_LSB     8
`define DMLS_LINK1_LSB     11
`define DMLS_LINK_W        3

// ****************************************************************
// Reset value, implemented-bit mask and special values.
// ****************************************************************
`define DMLS_CFG_RESET     16'h0000
`define DMLS_CFG_MASK      16'h3F3F
`define DMLS_SHARED_MASK   16'h0003
`define DMLS_STOP_CODE     16'hBEEF
`define DMLS_SPECIAL_DAC_A 3'h5
`define DMLS_SPECIAL_DAC_B 3'h6

`endif

// file: rtl/dmls_pkg.sv
// Types shared by the DAC and mailbox link router.
package dmls_pkg;

	// DAC number 1 to 6 as seen by the microcores.
	typedef logic [2:0] dmls_dac_t;

	// Channel index 0 to 2 and core index 0 to 5 (two per channel).
	typedef logic [1:0] dmls_chan_t;
	typedef logic [2:0] dmls_core_t;

	// Communication-link select codes.
	typedef enum logic [2:0] {
		DMLS_LINK_SSSC = 3'h0,
		DMLS_LINK_OSSC = 3'h1,
		DMLS_LINK_SSNC = 3'h2,
		DMLS_LINK_OSNC = 3'h3,
		DMLS_LINK_SUMH = 3'h4,
		DMLS_LINK_SUML = 3'h5,
		DMLS_LINK_SSPC = 3'h6,
		DMLS_LINK_OSPC = 3'h7
	} dmls_link_t;

endpackage : dmls_pkg

// file: rtl/dmls_top.sv
// DAC and communication-word routing for three channels of two cores.
//
// How it works
// - Each core reaches its own DAC pair, one other pair and a special pair.
// - Own pair: core zero gets 2n-1 then 2n; core one swapped.
// - Core zero, direction 0: other pair is the next channel's pair.
// - Core zero, direction 1: other pair is the previous channel's pair.
// - Core one, direction 0: next channel's pair, order swapped.
// - Core one, direction 1: previous channel's pair, order swapped.
// - Direction and special pair set by register bits or core instruction.
// - Special pair select 0 picks DAC five, 1 picks DAC six.
// - Shared-control bit 1 turns upper 8 control bits into status bits.
// - Link codes 0 to 3: same/other core, same/next channel.
// - Link code 4 sums top nibbles, code 5 second nibbles, of all words.
// - Link codes 6 and 7: same/other core on previous channel.
// - Next and previous channel wrap cyclically over three channels.
// - Each core's window shows exactly one core word at a time, or one of the two sums.
// - A core instruction sets its link target like a register write.
// - Writing BEEF to a channel's stop port halts that channel.
`timescale 1ns/1ps
`include "dmls_defs.svh"

module dmls_top #(
	parameter int N_CHAN = 3,
	parameter int WORD_W = 16
) (
	input  wire logic                          i_core_clk,
	input  wire logic                          i_reset_n,
	// Register port from the serial interface, same clock.
	input  wire logic                          i_reg_wr,
	input  wire logic                          i_reg_rd,
	input  wire logic [9:0]                    i_reg_addr,
	input  wire logic [15:0]                   i_reg_wdata,
	input  wire logic                          i_cfg_lock,
	output logic      [15:0]                   o_reg_rdata,
	output logic                               o_reg_rvalid,
	// Core instructions, one bit or field per core (index 2*chan+core).
	input  wire logic [2*N_CHAN-1:0]           i_dir_instr_set,
	input  wire logic [2*N_CHAN-1:0]           i_dir_instr_val,
	input  wire logic [2*N_CHAN-1:0]           i_select_special_pair_instr,
	input  wire logic [2*N_CHAN-1:0]           i_special_instr_val,
	input  wire logic [2*N_CHAN-1:0]           i_link_instr_set,
	input  wire logic [2*N_CHAN-1:0][2:0]      i_link_instr_val,
	// Communication words written by each core.
	input  wire logic [2*N_CHAN-1:0][WORD_W-1:0] i_comm_word,
	// Routing results per core.
	output dmls_pkg::dmls_dac_t [2*N_CHAN-1:0] o_dac_own_same,
	output dmls_pkg::dmls_dac_t [2*N_CHAN-1:0] o_dac_own_opp,
	output dmls_pkg::dmls_dac_t [2*N_CHAN-1:0] o_dac_other_same,
	output dmls_pkg::dmls_dac_t [2*N_CHAN-1:0] o_dac_other_opp,
	output dmls_pkg::dmls_dac_t [2*N_CHAN-1:0] o_special_dac_pair,
	output logic      [2*N_CHAN-1:0]           o_shared_control_split,
	output dmls_pkg::dmls_core_t [2*N_CHAN-1:0] o_link_target,
	output logic      [2*N_CHAN-1:0]           o_link_is_sum,
	output logic      [2*N_CHAN-1:0][WORD_W-1:0] o_link_rdata,
	// Halt request per channel, one-cycle pulse.
	output logic      [N_CHAN-1:0]             o_stop_chan
);
	import dmls_pkg::*;

	// ****************************************************************
	// Channel neighbour helpers.
	// ****************************************************************

	// Next channel, wrapping from the last back to the first.
	function automatic dmls_chan_t next_chan(input dmls_chan_t c);
		next_chan = (c == dmls_chan_t'(N_CHAN - 1)) ? 2'h0 : c + 2'h1;
	endfunction : next_chan

	// Previous channel, wrapping from the first back to the last.
	function automatic dmls_chan_t prev_chan(input dmls_chan_t c);
		prev_chan = (c == 2'h0) ? dmls_chan_t'(N_CHAN - 1) : c - 2'h1;
	endfunction : prev_chan

	// DAC number of the lower DAC of a channel's pair (1, 3 or 5).
	function automatic dmls_dac_t pair_base(input dmls_chan_t c);
		pair_base = {c, 1'b1};
	endfunction : pair_base

	// ****************************************************************
	// Address decode.
	// ****************************************************************

	logic [N_CHAN-1:0][9:0] cfg_addr;
	logic [N_CHAN-1:0][9:0] stop_addr;
	logic [N_CHAN-1:0]      cfg_hit;
	logic [N_CHAN-1:0]      stop_hit;

	// Printed offsets for each channel.
	assign cfg_addr[0]  = `DMLS_CFG_CH1_OFF;
	assign cfg_addr[1]  = `DMLS_CFG_CH2_OFF;
	assign cfg_addr[2]  = `DMLS_CFG_CH3_OFF;
	assign stop_addr[0] = `DMLS_STOP_CH1_OFF;
	assign stop_addr[1] = `DMLS_STOP_CH2_OFF;
	assign stop_addr[2] = `DMLS_STOP_CH3_OFF;

	// ****************************************************************
	// Per-channel configuration register and stop port.
	// ****************************************************************

	logic [N_CHAN-1:0][15:0] cfg_q;
	logic [N_CHAN-1:0][15:0] cfg_d;
	logic [N_CHAN-1:0]       stop_q;
	logic [N_CHAN-1:0]       stop_d;

	genvar gc;
	generate
		for (gc = 0; gc < N_CHAN; gc++) begin : g_chan
			// Decode this channel's two addresses.
			assign cfg_hit[gc]  = (i_reg_addr == cfg_addr[gc]);
			assign stop_hit[gc] = (i_reg_addr == stop_addr[gc]);

			// Only the exact code halts; any other word is ignored.
			assign stop_d[gc] = i_reg_wr && stop_hit[gc] &&
				(i_reg_wdata == `DMLS_STOP_CODE);

			// Next register value: host write, then core instructions.
			always_comb begin
				logic [15:0] keep;
				keep = cfg_q[gc];
				cfg_d[gc] = keep;
				if (i_reg_wr && cfg_hit[gc]) begin
					// Reserved bits are dropped by the mask.
					cfg_d[gc] = i_reg_wdata & `DMLS_CFG_MASK;
					if (i_cfg_lock) begin
						cfg_d[gc][1:0] = keep[1:0];
					end
				end
				for (int u = 0; u < 2; u++) begin
					if (i_dir_instr_set[2*gc+u]) begin
						cfg_d[gc][`DMLS_DIR_LSB+u] =
							i_dir_instr_val[2*gc+u];
					end
					if (i_select_special_pair_instr[2*gc+u]) begin
						cfg_d[gc][`DMLS_SPECIAL_LSB+u] =
							i_special_instr_val[2*gc+u];
					end
					if (i_link_instr_set[2*gc+u]) begin
						cfg_d[gc][`DMLS_LINK0_LSB+3*u +: `DMLS_LINK_W] =
							i_link_instr_val[2*gc+u];
					end
				end
			end

			// Register storage with synchronous reset to zero.
			always_ff @(posedge i_core_clk) begin
				if (!i_reset_n) begin
					cfg_q[gc]  <= `DMLS_CFG_RESET;
					stop_q[gc] <= 1'b0;
				end else begin
					cfg_q[gc]  <= cfg_d[gc];
					stop_q[gc] <= stop_d[gc];
				end
			end
		end
	endgenerate

	// Halt pulses come straight from their flip-flops.
	assign o_stop_chan = stop_q;

	// ****************************************************************
	// Register read path.
	// ****************************************************************

	logic [15:0] rd_word;
	logic [15:0] rdata_q;
	logic        rvalid_q;

	// Configuration reads return stored fields; stop port and unmapped
	// addresses return zero because nothing is stored there.
	always_comb begin
		rd_word = 16'h0000;
		for (int c = 0; c < N_CHAN; c++) begin
			if (cfg_hit[c]) begin
				rd_word = cfg_q[c] & `DMLS_CFG_MASK;
			end
		end
	end

	// Read data is held until the next read; valid pulses one cycle.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			rdata_q  <= 16'h0000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= i_reg_rd;
			if (i_reg_rd) begin
				rdata_q <= rd_word;
			end
		end
	end

	assign o_reg_rdata  = rdata_q;
	assign o_reg_rvalid = rvalid_q;

	// ****************************************************************
	// Nibble sums over all communication words.
	// ****************************************************************

	logic [7:0] sum_hi;
	logic [7:0] sum_lo;

	// Sum of the top nibbles and of the second nibbles of every word.
	always_comb begin
		sum_hi = 8'h00;
		sum_lo = 8'h00;
		for (int k = 0; k < 2 * N_CHAN; k++) begin
			sum_hi = sum_hi + {4'h0, i_comm_word[k][WORD_W-1 -: 4]};
			sum_lo = sum_lo + {4'h0, i_comm_word[k][WORD_W-5 -: 4]};
		end
	end

	// ****************************************************************
	// Per-core routing.
	// ****************************************************************

	dmls_dac_t  [2*N_CHAN-1:0]             own_same_q;
	dmls_dac_t  [2*N_CHAN-1:0]             own_opp_q;
	dmls_dac_t  [2*N_CHAN-1:0]             oth_same_q;
	dmls_dac_t  [2*N_CHAN-1:0]             oth_opp_q;
	dmls_dac_t  [2*N_CHAN-1:0]             special_q;
	logic       [2*N_CHAN-1:0]             split_q;
	dmls_core_t [2*N_CHAN-1:0]             target_q;
	logic       [2*N_CHAN-1:0]             is_sum_q;
	logic       [2*N_CHAN-1:0][WORD_W-1:0] link_q;

	genvar gk;
	generate
		for (gk = 0; gk < 2 * N_CHAN; gk++) begin : g_core
			localparam int CH = gk / 2;
			localparam int CU = gk % 2;

			dmls_chan_t own_ch;
			dmls_chan_t oth_ch;
			dmls_chan_t tgt_ch;
			logic       dir;
			logic       spc;
			logic       shr;
			logic       tgt_other;
			dmls_link_t code;
			dmls_core_t tgt;
			logic       sum_mode;
			logic [WORD_W-1:0] win;
			dmls_dac_t  own_lo;
			dmls_dac_t  oth_lo;

			// Field pick-up for this core.
			assign own_ch = dmls_chan_t'(CH);
			assign shr = cfg_q[CH][`DMLS_SHARED_LSB+CU];
			assign dir = cfg_q[CH][`DMLS_DIR_LSB+CU];
			assign spc = cfg_q[CH][`DMLS_SPECIAL_LSB+CU];
			assign code = dmls_link_t'(
				cfg_q[CH][`DMLS_LINK0_LSB+3*CU +: `DMLS_LINK_W]);

			// Other channel: 0 picks the next, 1 the previous.
			assign oth_ch = dir ? prev_chan(own_ch)
			                    : next_chan(own_ch);
			assign own_lo = pair_base(own_ch);
			assign oth_lo = pair_base(oth_ch);

			// Link target channel and which core of that channel.
			always_comb begin
				tgt_ch    = own_ch;
				tgt_other = 1'b0;
				sum_mode  = 1'b0;
				case (code)
					DMLS_LINK_SSSC: tgt_ch = own_ch;
					DMLS_LINK_OSSC: begin
						tgt_ch    = own_ch;
						tgt_other = 1'b1;
					end
					DMLS_LINK_SSNC: tgt_ch = next_chan(own_ch);
					DMLS_LINK_OSNC: begin
						tgt_ch    = next_chan(own_ch);
						tgt_other = 1'b1;
					end
					DMLS_LINK_SUMH: sum_mode = 1'b1;
					DMLS_LINK_SUML: sum_mode = 1'b1;
					DMLS_LINK_SSPC: tgt_ch = prev_chan(own_ch);
					DMLS_LINK_OSPC: begin
						tgt_ch    = prev_chan(own_ch);
						tgt_other = 1'b1;
					end
					default: tgt_ch = own_ch;
				endcase
			end

			// Exactly one core word is selected, or one of the sums.
			assign tgt = {tgt_ch, tgt_other ^ CU[0]};
			assign win = (code == DMLS_LINK_SUMH) ? WORD_W'(sum_hi) :
			             (code == DMLS_LINK_SUML) ? WORD_W'(sum_lo) :
			             i_comm_word[tgt];

			// Routing results are registered so every output is a flop.
			always_ff @(posedge i_core_clk) begin
				if (!i_reset_n) begin
					own_same_q[gk] <= 3'h0;
					own_opp_q[gk]  <= 3'h0;
					oth_same_q[gk] <= 3'h0;
					oth_opp_q[gk]  <= 3'h0;
					special_q[gk]  <= 3'h0;
					split_q[gk]    <= 1'b0;
					target_q[gk]   <= 3'h0;
					is_sum_q[gk]   <= 1'b0;
					link_q[gk]     <= '0;
				end else begin
					// Core one sees each pair with its two DACs swapped.
					own_same_q[gk] <= own_lo + 3'(CU);
					own_opp_q[gk]  <= own_lo + 3'(1 - CU);
					oth_same_q[gk] <= oth_lo + 3'(CU);
					oth_opp_q[gk]  <= oth_lo + 3'(1 - CU);
					special_q[gk]  <= spc ? `DMLS_SPECIAL_DAC_B
					                      : `DMLS_SPECIAL_DAC_A;
					split_q[gk]    <= shr;
					target_q[gk]   <= tgt;
					is_sum_q[gk]   <= sum_mode;
					link_q[gk]     <= win;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Output assignment.
	// ****************************************************************

	// All routing outputs come straight from the per-core flops.
	assign o_dac_own_same         = own_same_q;
	assign o_dac_own_opp          = own_opp_q;
	assign o_dac_other_same       = oth_same_q;
	assign o_dac_other_opp        = oth_opp_q;
	assign o_special_dac_pair     = special_q;
	assign o_shared_control_split = split_q;
	assign o_link_target          = target_q;
	assign o_link_is_sum          = is_sum_q;
	assign o_link_rdata           = link_q;

endmodule : dmls_top
